// file: verilog/scc_pkg.sv
// constants, types and crystal translation for the system clock controller
// assumes a single 125 MHz bus clock and software access over a plain port
package scc_pkg;

	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned GATE_W = 32;
	localparam int unsigned NSYNC  = 5;

	// register offsets
	localparam logic [7:0] OFS_STATUS   = 8'h00;
	localparam logic [7:0] OFS_RUN_CFG  = 8'h04;
	localparam logic [7:0] OFS_XLATE    = 8'h08;
	localparam logic [7:0] OFS_RUN_EXT  = 8'h0C;
	localparam logic [7:0] OFS_RUN_GATE = 8'h10;
	localparam logic [7:0] OFS_SLP_GATE = 8'h14;
	localparam logic [7:0] OFS_DSL_GATE = 8'h18;
	localparam logic [7:0] OFS_DSL_CFG  = 8'h1C;

	// run_clock_config fields
	localparam int unsigned RC_MAIN_OSC_DIS = 0;
	localparam int unsigned RC_SRC_LO   = 4;
	localparam int unsigned RC_CRYSTAL_SELECT_LO  = 6;
	localparam int unsigned RC_BYPASS   = 11;
	localparam int unsigned RC_PWRDN    = 13;
	localparam int unsigned RC_USESYS   = 22;
	localparam int unsigned RC_DIV_LO   = 23;
	localparam int unsigned RC_AUTOGATE = 27;
	// run_clock_config_ext fields
	localparam int unsigned RX_SRC_LO   = 4;
	localparam int unsigned RX_BYPASS   = 11;
	localparam int unsigned RX_PWRDN    = 13;
	localparam int unsigned RX_DIV_LO   = 23;
	localparam int unsigned RX_USE      = 31;
	// deepsleep_clock_config and status fields
	localparam int unsigned DC_SRC_LO   = 4;
	localparam int unsigned ST_LOCK     = 0;
	localparam int unsigned ST_BUSY     = 1;
	localparam int unsigned ST_MODE_LO  = 2;
	localparam int unsigned ST_SRC_LO   = 5;

	localparam logic [31:0] RUN_CFG_RST  = 32'h0780_2AD1;
	localparam logic [31:0] RUN_EXT_RST  = 32'h0780_2810;
	localparam logic [31:0] GATE_RST     = 32'h0000_0040;
	localparam logic [31:0] DSL_CFG_RST  = 32'h0000_0000;

	// relock period in main oscillator cycles
	localparam logic [12:0] RELOCK_LOAD  = 13'h1200;
	localparam logic [5:0]  DS_DIV_BASE  = 6'h0F;
	localparam logic [5:0]  DS_DIV_EXT   = 6'h3F;

	typedef enum logic [2:0] {
		SRC_MAIN = 3'h0,
		SRC_INT  = 3'h1,
		SRC_INT4 = 3'h2,
		SRC_SLOW = 3'h3,
		SRC_RTC  = 3'h4,
		SRC_PLL  = 3'h5
	} scc_src_t;

	typedef enum logic [2:0] {
		PM_RUN      = 3'b000,
		PM_DS_ENTER = 3'b001,
		PM_DEEP     = 3'b011,
		PM_DS_EXIT  = 3'b010,
		PM_SLEEP    = 3'b100
	} scc_pmode_t;

	// source and divide value (value minus one) handed to the mux
	typedef struct packed {
		scc_src_t   sel;
		logic [5:0] div;
	} scc_mux_cfg_t;

	// crystal code to {multiplier[9:0], divider[3:0]} for a 400 MHz VCO
	function automatic logic [13:0] scc_xlate(input logic [3:0] code);
		case (code)
			4'h0: scc_xlate = {10'd400, 4'd1};
			4'h1: scc_xlate = {10'd217, 4'd1};
			4'h2: scc_xlate = {10'd200, 4'd1};
			4'h3: scc_xlate = {10'd651, 4'd4};
			4'h4: scc_xlate = {10'd447, 4'd4};
			4'h5: scc_xlate = {10'd217, 4'd2};
			4'h6: scc_xlate = {10'd100, 4'd1};
			4'h7: scc_xlate = {10'd293, 4'd3};
			4'h8: scc_xlate = {10'd407, 4'd5};
			4'h9: scc_xlate = {10'd80, 4'd1};
			4'hA: scc_xlate = {10'd625, 4'd8};
			4'hB: scc_xlate = {10'd200, 4'd3};
			4'hC: scc_xlate = {10'd521, 4'd8};
			4'hD: scc_xlate = {10'd217, 4'd4};
			4'hE: scc_xlate = {10'd50, 4'd1};
			default: scc_xlate = {10'd293, 4'd6};
		endcase
	endfunction

endpackage

// file: verilog/scc_relock.sv
// relock timer: down counter stepped by main oscillator edges
// assumes tick_i is already synchronised and one bus cycle long
`timescale 1ns/1ps
module scc_relock (
	input  wire logic clk_i,
	input  wire logic sys_rst_i,
	input  wire logic tick_i,
	input  wire logic trig_i,
	output logic      ready_o,
	output logic      busy_o,
	output logic      lock_o
);
	import scc_pkg::*;

	logic [12:0] cnt;
	logic [12:0] next_cnt;
	logic        busy;
	logic        next_busy;
	logic        locked;
	logic        next_locked;
	logic        next_lock;

	always_comb begin
		next_cnt    = cnt;
		next_busy   = busy;
		next_locked = locked;
		next_lock   = 1'b0;
		if (trig_i) begin
			next_cnt  = RELOCK_LOAD;
			next_busy = 1'b1;
		end else if (busy && tick_i) begin
			next_cnt = cnt - 13'h0001;
			if (cnt == 13'h0001) begin
				next_busy   = 1'b0;
				next_locked = 1'b1;
				next_lock   = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			cnt    <= 13'h0000;
			busy   <= 1'b0;
			locked <= 1'b0;
			lock_o <= 1'b0;
		end else begin
			cnt    <= next_cnt;
			busy   <= next_busy;
			locked <= next_locked;
			lock_o <= next_lock;
		end
	end

	// a trigger in this very cycle already voids readiness
	assign ready_o = locked && !busy && !trig_i;
	assign busy_o  = busy;

	AST_RELOCK_LOAD: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		trig_i |=> (cnt == RELOCK_LOAD) && busy)
		else $error("relock counter not loaded");
	AST_RELOCK_STEP: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(busy && tick_i && !trig_i && cnt > 13'h0001) |=>
		cnt == $past(cnt) - 13'h0001 && busy)
		else $error("relock counter did not step");
	AST_LOCK_AT_ZERO: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		lock_o |-> cnt == 13'h0000 && !busy && $past(busy))
		else $error("lock raised before counter expired");
	COV_RELOCK_DONE: cover property (@(posedge clk_i) disable iff (sys_rst_i)
		lock_o);
endmodule

// file: verilog/scc_clk_mux.sv
// glitch-free source switch and divider for the system clock level
// assumes source levels are synchronised and much slower than clk_i
`timescale 1ns/1ps
module scc_clk_mux (
	input  wire logic                  clk_i,
	input  wire logic                  sys_rst_i,
	input  wire logic [5:0]            src_lvl_i,
	input  wire scc_pkg::scc_mux_cfg_t cfg_i,
	output logic                       clk_o,
	output logic                       tick_o,
	output logic                       busy_o
);
	import scc_pkg::*;

	scc_mux_cfg_t cur;
	scc_mux_cfg_t next_cur;
	logic [5:0]   cnt;
	logic [5:0]   next_cnt;
	logic [5:0]   half;
	logic         next_out;
	logic         next_tick;
	logic         prev;
	logic         next_prev;
	logic         lvl_cur;
	logic         switch_ok;

	assign lvl_cur   = src_lvl_i[cur.sel];
	assign half      = (cur.div >> 1) + 6'h01;
	// switch only with old output low and new source low: phases only grow
	assign switch_ok = (cfg_i != cur) && !clk_o && !src_lvl_i[cfg_i.sel];

	always_comb begin
		next_cur  = cur;
		next_cnt  = cnt;
		next_out  = clk_o;
		next_prev = lvl_cur;
		if (switch_ok) begin
			next_cur  = cfg_i;
			next_cnt  = cfg_i.div;
			next_out  = 1'b0;
			next_prev = 1'b0;
		end else if (cur.div == 6'h00) begin
			next_out = lvl_cur;
		end else if (lvl_cur && !prev) begin
			next_cnt = (cnt == cur.div) ? 6'h00 : cnt + 6'h01;
			next_out = next_cnt < half;
		end
		next_tick = next_out && !clk_o;
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			cur    <= '{sel: SRC_INT, div: 6'h00};
			cnt    <= 6'h00;
			clk_o  <= 1'b0;
			tick_o <= 1'b0;
			prev   <= 1'b0;
		end else begin
			cur    <= next_cur;
			cnt    <= next_cnt;
			clk_o  <= next_out;
			tick_o <= next_tick;
			prev   <= next_prev;
		end
	end

	assign busy_o = (cfg_i != cur);

	AST_SWITCH_ON_LOW: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(cur != $past(cur)) |-> !clk_o && !$past(clk_o))
		else $error("source switched with clock high");
	AST_NO_SHORT_HIGH: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		$rose(clk_o) ##1 (cur != $past(cur)) |-> 1'b0)
		else $error("switch cut a high phase");
	COV_SWITCH: cover property (@(posedge clk_i) disable iff (sys_rst_i)
		cur.sel != $past(cur.sel));
endmodule

// file: verilog/scc_clock_ctrl.sv
// system clock controller: source select, relock timing, mode gating
// assumes oscillator levels arrive from other domains; core signals on clk_i
//
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps

module scc_clock_ctrl (
	input  wire logic               clk_i,
	input  wire logic               sys_rst_i,
	input  wire logic [7:0]         reg_addr_i,
	input  wire logic [31:0]        reg_wdata_i,
	input  wire logic               reg_wr_i,
	input  wire logic               reg_rd_i,
	output logic      [31:0]        reg_rdata_o,
	input  wire logic               internal_osc_i,
	input  wire logic               main_osc_i,
	input  wire logic               slow_osc_i,
	input  wire logic               rtc_osc_i,
	input  wire logic               pll_clk_i,
	input  wire logic               wait_for_interrupt_request_i,
	input  wire logic               deepsleep_en_i,
	input  wire logic               wake_irq_i,
	output logic                    sys_clk_o,
	output logic                    sys_tick_o,
	output logic                    cpu_clk_en_o,
	output logic      [31:0]        periph_clk_en_o,
	output logic                    pll_pwrdn_o,
	output logic      [13:0]        pll_translation_o,
	output logic                    main_osc_pwrdn_o,
	output logic                    slow_osc_en_o,
	output scc_pkg::scc_pmode_t     power_mode_o
);
	import scc_pkg::*;

	logic [NSYNC-1:0] raw;
	logic [NSYNC-1:0] sync1;
	logic [NSYNC-1:0] sync2;
	logic             main_osc_prev;
	logic             internal_osc_prev;
	logic [1:0]       internal_osc_cnt;
	logic             main_osc_tick;

	assign raw = {pll_clk_i, rtc_osc_i, slow_osc_i, main_osc_i,
		internal_osc_i};

	// oscillators are foreign domains: two flops before any use
	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++) begin : g_sync
			always_ff @(posedge clk_i) begin
				if (sys_rst_i) begin
					sync1[gi] <= 1'b0;
					sync2[gi] <= 1'b0;
				end else begin
					sync1[gi] <= raw[gi];
					sync2[gi] <= sync1[gi];
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			main_osc_prev <= 1'b0;
			internal_osc_prev <= 1'b0;
			internal_osc_cnt  <= 2'b00;
		end else begin
			main_osc_prev <= sync2[1];
			internal_osc_prev <= sync2[0];
			internal_osc_cnt  <= internal_osc_cnt + {1'b0, sync2[0] & ~internal_osc_prev};
		end
	end
	assign main_osc_tick = sync2[1] & ~main_osc_prev;

	// registers
	logic [31:0] run_clock_config;
	logic [31:0] run_clock_config_ext;
	logic [31:0] run_gating_regs;
	logic [31:0] sleep_gating_regs;
	logic [31:0] deepsleep_gating_regs;
	logic [31:0] deepsleep_clock_config;
	logic        pll_lock_raw_status;
	logic [31:0] next_run_cfg;
	logic [31:0] next_run_ext;
	logic [31:0] next_run_gate;
	logic [31:0] next_slp_gate;
	logic [31:0] next_dsl_gate;
	logic [31:0] next_dsl_cfg;
	logic        next_lock_raw;
	logic [31:0] next_rdata;
	logic [13:0] next_xlate;
	logic        crystal_select_changed;
	logic        relock_trig;
	logic        relock_ready;
	logic        relock_busy;
	logic        relock_done;
	logic        pll_pd_eff;
	logic        pll_pd_prev;
	logic [2:0]  sys_src;
	scc_pmode_t  state;
	scc_pmode_t  next_state;

	assign crystal_select_changed = reg_wr_i && reg_addr_i == OFS_RUN_CFG &&
		reg_wdata_i[RC_CRYSTAL_SELECT_LO +: 4] != run_clock_config[RC_CRYSTAL_SELECT_LO +: 4];

	always_comb begin
		next_run_cfg  = run_clock_config;
		next_run_ext  = run_clock_config_ext;
		next_run_gate = run_gating_regs;
		next_slp_gate = sleep_gating_regs;
		next_dsl_gate = deepsleep_gating_regs;
		next_dsl_cfg  = deepsleep_clock_config;
		next_lock_raw = pll_lock_raw_status;
		next_rdata    = 32'h0000_0000;
		if (reg_wr_i) begin
			case (reg_addr_i)
				OFS_STATUS: begin
					if (reg_wdata_i[ST_LOCK])
						next_lock_raw = 1'b0;
				end
				OFS_RUN_CFG:  next_run_cfg  = reg_wdata_i;
				OFS_RUN_EXT:  next_run_ext  = reg_wdata_i;
				OFS_RUN_GATE: next_run_gate = reg_wdata_i;
				OFS_SLP_GATE: next_slp_gate = reg_wdata_i;
				OFS_DSL_GATE: next_dsl_gate = reg_wdata_i;
				OFS_DSL_CFG:  next_dsl_cfg  = reg_wdata_i;
				default: ;
			endcase
		end
		// a lock in the software clear cycle survives
		if (relock_done)
			next_lock_raw = 1'b1;
		// a lock from the old setting is void once a new relock starts
		if (relock_trig)
			next_lock_raw = 1'b0;
		if (reg_rd_i) begin
			case (reg_addr_i)
				OFS_STATUS: next_rdata = {24'h00_0000, sys_src, 1'b0,
					state[1:0], relock_busy, pll_lock_raw_status};
				OFS_RUN_CFG:  next_rdata = run_clock_config;
				OFS_XLATE:    next_rdata = {18'h0_0000, pll_translation_o};
				OFS_RUN_EXT:  next_rdata = run_clock_config_ext;
				OFS_RUN_GATE: next_rdata = run_gating_regs;
				OFS_SLP_GATE: next_rdata = sleep_gating_regs;
				OFS_DSL_GATE: next_rdata = deepsleep_gating_regs;
				OFS_DSL_CFG:  next_rdata = deepsleep_clock_config;
				default:      next_rdata = 32'h0000_0000;
			endcase
		end
		next_xlate = scc_xlate(run_clock_config[RC_CRYSTAL_SELECT_LO +: 4]);
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			run_clock_config       <= RUN_CFG_RST;
			run_clock_config_ext   <= RUN_EXT_RST;
			run_gating_regs        <= GATE_RST;
			sleep_gating_regs      <= GATE_RST;
			deepsleep_gating_regs  <= GATE_RST;
			deepsleep_clock_config <= DSL_CFG_RST;
			pll_lock_raw_status    <= 1'b0;
			reg_rdata_o            <= 32'h0000_0000;
			pll_translation_o      <= 14'h0000;
		end else begin
			run_clock_config       <= next_run_cfg;
			run_clock_config_ext   <= next_run_ext;
			run_gating_regs        <= next_run_gate;
			sleep_gating_regs      <= next_slp_gate;
			deepsleep_gating_regs  <= next_dsl_gate;
			deepsleep_clock_config <= next_dsl_cfg;
			pll_lock_raw_status    <= next_lock_raw;
			reg_rdata_o            <= next_rdata;
			pll_translation_o      <= next_xlate;
		end
	end

	// effective clock configuration
	logic         use_ext;
	logic         run_pd;
	logic         run_bypass;
	logic         autogate;
	logic         deep_act;
	logic         pll_was_on;
	logic         next_pll_was_on;
	logic [2:0]   raw_src;
	logic [2:0]   ds_src;
	logic [5:0]   run_div;
	scc_mux_cfg_t mux_cfg;
	logic         mux_busy;

	always_comb begin
		use_ext  = run_clock_config_ext[RX_USE];
		autogate = run_clock_config[RC_AUTOGATE];
		ds_src   = deepsleep_clock_config[DC_SRC_LO +: 3];
		deep_act = (state == PM_DS_ENTER) || (state == PM_DEEP);
		if (use_ext) begin
			raw_src    = run_clock_config_ext[RX_SRC_LO +: 3];
			run_pd     = run_clock_config_ext[RX_PWRDN];
			run_bypass = run_clock_config_ext[RX_BYPASS];
			run_div    = run_clock_config_ext[RX_DIV_LO +: 6];
		end else begin
			raw_src    = {1'b0, run_clock_config[RC_SRC_LO +: 2]};
			run_pd     = run_clock_config[RC_PWRDN];
			run_bypass = run_clock_config[RC_BYPASS];
			run_div    = run_clock_config[RC_USESYS] ?
				{2'b00, run_clock_config[RC_DIV_LO +: 4]} : 6'h00;
		end
		if (raw_src > SRC_RTC)
			raw_src = SRC_MAIN;
		// bypass passes the raw source undivided
		mux_cfg.sel = scc_src_t'(raw_src);
		mux_cfg.div = run_bypass ? 6'h00 : run_div;
		// PLL held off until relocked
		if (!run_bypass && !run_pd && relock_ready)
			mux_cfg.sel = SRC_PLL;
		if (deep_act) begin
			mux_cfg.sel = (ds_src == SRC_INT || ds_src == SRC_SLOW) ?
				scc_src_t'(ds_src) : SRC_MAIN;
			mux_cfg.div = pll_was_on ?
				(use_ext ? DS_DIV_EXT : DS_DIV_BASE) : 6'h00;
		end
		pll_pd_eff = run_pd || (deep_act && pll_was_on);
		sys_src    = mux_cfg.sel;
	end

	assign pll_pwrdn_o      = pll_pd_eff;
	assign main_osc_pwrdn_o = deep_act ? (mux_cfg.sel != SRC_MAIN) :
		run_clock_config[RC_MAIN_OSC_DIS];
	assign slow_osc_en_o    = (mux_cfg.sel == SRC_SLOW);
	assign relock_trig      = crystal_select_changed ||
		(pll_pd_prev && !pll_pd_eff);

	always_ff @(posedge clk_i) begin
		if (sys_rst_i)
			pll_pd_prev <= 1'b1;
		else
			pll_pd_prev <= pll_pd_eff;
	end

	scc_relock u_relock (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.tick_i    (main_osc_tick),
		.trig_i    (relock_trig),
		.ready_o   (relock_ready),
		.busy_o    (relock_busy),
		.lock_o    (relock_done)
	);

	scc_clk_mux u_mux (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.src_lvl_i ({sync2[4], sync2[3], sync2[2], internal_osc_cnt[1], sync2[0],
			sync2[1]}),
		.cfg_i     (mux_cfg),
		.clk_o     (sys_clk_o),
		.tick_o    (sys_tick_o),
		.busy_o    (mux_busy)
	);

	// power modes
	logic [31:0] next_periph;
	logic        next_cpu_en;

	always_comb begin
		next_state      = state;
		next_pll_was_on = pll_was_on;
		case (state)
			PM_RUN: begin
				if (wait_for_interrupt_request_i) begin
					next_state = deepsleep_en_i ? PM_DS_ENTER
						: PM_SLEEP;
					next_pll_was_on = deepsleep_en_i && !run_pd;
				end
			end
			PM_SLEEP: if (wake_irq_i) next_state = PM_RUN;
			// a source stuck high stalls here: software's duty
			PM_DS_ENTER: if (!mux_busy) next_state = PM_DEEP;
			PM_DEEP: if (wake_irq_i) next_state = PM_DS_EXIT;
			PM_DS_EXIT: begin
				// a pll in use must relock before the core restarts on it
				if (!mux_busy && (!pll_was_on || relock_ready)) begin
					next_state      = PM_RUN;
					next_pll_was_on = 1'b0;
				end
			end
			default: next_state = PM_RUN;
		endcase
		next_cpu_en = (next_state == PM_RUN);
		case (next_state)
			PM_RUN:   next_periph = run_gating_regs;
			PM_SLEEP: next_periph = autogate ? sleep_gating_regs
				: run_gating_regs;
			default:  next_periph = autogate ? deepsleep_gating_regs
				: run_gating_regs;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			state           <= PM_RUN;
			pll_was_on      <= 1'b0;
			cpu_clk_en_o    <= 1'b1;
			periph_clk_en_o <= GATE_RST;
		end else begin
			state           <= next_state;
			pll_was_on      <= next_pll_was_on;
			cpu_clk_en_o    <= next_cpu_en;
			periph_clk_en_o <= next_periph;
		end
	end
	assign power_mode_o = state;

	AST_RESET_SOURCE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		$fell(sys_rst_i) |-> mux_cfg.sel == SRC_INT && pll_pwrdn_o)
		else $error("reset did not select internal oscillator");
	AST_PLL_BLOCKED: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		mux_cfg.sel == SRC_PLL |-> !relock_busy && !relock_trig)
		else $error("PLL selected during relock");
	AST_CRYSTAL_SELECT_RELOCK: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		crystal_select_changed |=> relock_busy && !pll_lock_raw_status)
		else $error("crystal change did not relock");
	AST_SAME_CRYSTAL_SELECT: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(reg_wr_i && reg_addr_i == OFS_RUN_CFG && !crystal_select_changed &&
		!(pll_pd_prev && !pll_pd_eff)) |-> !relock_trig)
		else $error("unchanged crystal started relock");
	AST_POWERUP_RELOCK: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		$fell(pll_pd_eff) |-> relock_trig ##1 relock_busy)
		else $error("PLL power-up did not relock");
	AST_SLEEP_GATE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(state == PM_RUN && wait_for_interrupt_request_i && !deepsleep_en_i)
		|=> state == PM_SLEEP && !cpu_clk_en_o && periph_clk_en_o ==
		($past(autogate) ? $past(sleep_gating_regs) : $past(run_gating_regs)))
		else $error("sleep gating wrong");
	AST_DEEP_DIV: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(state == PM_DEEP && pll_was_on) |-> pll_pwrdn_o &&
		mux_cfg.div == (use_ext ? DS_DIV_EXT : DS_DIV_BASE))
		else $error("deep sleep divider not forced");
	AST_EXIT_ORDER: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(state == PM_DS_EXIT && mux_busy) |=> !cpu_clk_en_o)
		else $error("clocks resumed before restore");
	AST_WAKE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(state == PM_SLEEP && wake_irq_i) |=> state == PM_RUN && cpu_clk_en_o)
		else $error("interrupt did not wake");
	AST_EXT_PRIO: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(use_ext && !deep_act) |-> pll_pd_eff == run_clock_config_ext[RX_PWRDN])
		else $error("extended field ignored");
	COV_DEEP_ROUND: cover property (@(posedge clk_i) disable iff (sys_rst_i)
		state == PM_DS_EXIT ##1 state == PM_RUN);
	COV_PLL_SEL: cover property (@(posedge clk_i) disable iff (sys_rst_i)
		mux_cfg.sel == SRC_PLL && !mux_busy);
	COV_SLEEP: cover property (@(posedge clk_i) disable iff (sys_rst_i)
		state == PM_SLEEP ##1 state == PM_RUN);
endmodule

// file: test/scc_osc_model.sv
// oscillator sources and pll output for the clock controller bench
// assumes clk_i is the 125 MHz bus clock; all levels are counter taps
`timescale 1ns/1ps
module scc_osc_model (
	input  wire logic clk_i,
	input  wire logic main_pwrdn_i,
	input  wire logic pll_pwrdn_i,
	output logic      int_o,
	output logic      main_o,
	output logic      slow_o,
	output logic      rtc_o,
	output logic      pll_o
);
	logic [7:0] cnt = 8'h00;
	always @(posedge clk_i) begin
		cnt <= cnt + 8'h01;
	end
	assign int_o  = cnt[1];
	// a powered-down crystal stays flat, so no relock ticks sneak in
	assign main_o = cnt[2] & ~main_pwrdn_i; // reference in pll range
	assign slow_o = cnt[7];
	assign rtc_o  = cnt[6];
	assign pll_o  = cnt[1] & ~pll_pwrdn_i; // no output when down
endmodule

// file: test/system_clock_and_pll_control_test.sv
// self-checking bench for the system clock controller
// assumes the oscillator model; software and core are played here
`timescale 1ns/1ps
module system_clock_and_pll_control_test;
	import scc_pkg::*;
	logic        clk_i, sys_rst_i, reg_wr_i, reg_rd_i;
	logic [7:0]  reg_addr_i;
	logic [31:0] reg_wdata_i, reg_rdata_o, periph, rd_d, rg, sg, dg;
	logic        slp_req, dslp, wake, cpu_en, pll_pd, main_pd;
	logic        sclk, stick, slow_en;
	int          n_tk, n_hi;
	logic        s_int, s_main, s_slow, s_rtc, s_pll;
	logic [13:0] xl;
	scc_pmode_t  pm;
	int          error_cnt, comparisons;

	scc_clock_ctrl u_scc_clock_ctrl (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
		.internal_osc_i(s_int), .main_osc_i(s_main), .slow_osc_i(s_slow),
		.rtc_osc_i(s_rtc), .pll_clk_i(s_pll),
		.wait_for_interrupt_request_i(slp_req), .deepsleep_en_i(dslp),
		.wake_irq_i(wake), .sys_clk_o(sclk), .sys_tick_o(stick),
		.cpu_clk_en_o(cpu_en),
		.periph_clk_en_o(periph), .pll_pwrdn_o(pll_pd),
		.pll_translation_o(xl), .main_osc_pwrdn_o(main_pd),
		.slow_osc_en_o(slow_en),
		.power_mode_o(pm));
	scc_osc_model u_scc_osc_model (.clk_i(clk_i), .main_pwrdn_i(main_pd),
		.pll_pwrdn_i(pll_pd), .int_o(s_int), .main_o(s_main), .slow_o(s_slow),
		.rtc_o(s_rtc), .pll_o(s_pll));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop;
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic tmo(input int n, input int lim);
		if (n >= lim) begin
			error_cnt++;
			$display("[ERR] %0t wait timed out", $time);
			report_and_stop;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		#1 rd_d = reg_rdata_o;
	endtask
	task automatic wait_mode(input scc_pmode_t m, input int lim);
		int n;
		for (n = 0; n < lim && pm !== m; n++) begin
			@(posedge clk_i);
			#1;
		end
		tmo(n, lim);
	endtask
	task automatic wait_stat(input logic [31:0] k, v, input int lim);
		int n;
		rd(OFS_STATUS);
		for (n = 0; n < lim && (rd_d & k) !== v; n++) rd(OFS_STATUS);
		tmo(n, lim);
	endtask
	function automatic logic [31:0] exp_gate(input logic ag, input logic dp);
		if (!ag) return rg;
		return dp ? dg : sg;
	endfunction
	// one sleep or deep-sleep round trip with the pll as run source
	task automatic nap(input logic dp, input logic ag);
		wr(OFS_RUN_CFG, 32'h0780_02D0 | {4'h0, ag, 27'h0});
		@(posedge clk_i);
		dslp <= dp; // enable set a cycle ahead of the request
		@(posedge clk_i);
		slp_req <= 1'b1;
		@(posedge clk_i);
		slp_req <= 1'b0;
		wait_mode(dp ? PM_DEEP : PM_SLEEP, 4000);
		@(posedge clk_i);
		#1;
		chk(cpu_en, 1'b0);
		chk(periph, exp_gate(ag, dp));
		if (dp) chk({pll_pd, main_pd, slow_en}, 3'b100);
		@(posedge clk_i);
		wake <= 1'b1;
		// deep exit waits out a full relock, hence the long bound
		wait_mode(PM_RUN, 45000);
		@(posedge clk_i);
		wake <= 1'b0;
		#1;
		chk(cpu_en, 1'b1);
		chk(periph, rg);
		rd(OFS_STATUS);
		chk(rd_d[7:5], 3'h5);
	endtask

	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	initial begin
		{sys_rst_i, reg_wr_i, reg_rd_i, slp_req, dslp, wake} = 6'b10_0000;
		reg_addr_i = 8'h00;
		reg_wdata_i = 32'h0000_0000;
		error_cnt = 0;
		comparisons = 0;
		void'($urandom(32'h80e8_d773));
		rg = $urandom();
		sg = $urandom();
		dg = $urandom();
		repeat (3) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		@(posedge clk_i);
		#1;
		chk({pm, cpu_en, pll_pd}, 5'b00011);
		chk(periph, GATE_RST);
		chk(xl, {10'd200, 4'd3});
		rd(OFS_STATUS);
		chk(rd_d[7:5], 3'h1);
		rd(OFS_RUN_CFG);
		chk(rd_d, 32'h0780_2AD1);
		rd(8'h20);
		chk(rd_d, 32'h0000_0000);
		wr(OFS_RUN_GATE, rg);
		wr(OFS_SLP_GATE, sg);
		wr(OFS_DSL_GATE, dg);
		// crystal running well before the pll is relied on
		wr(OFS_RUN_CFG, 32'h0780_2990);
		rd(OFS_XLATE);
		chk(rd_d, {10'd100, 4'd1});
		rd(OFS_STATUS);
		chk(rd_d[1:0], 2'b10);
		wr(OFS_XLATE, $urandom());
		wr(OFS_RUN_CFG, 32'h0780_0AD0);
		rd(OFS_XLATE);
		chk(rd_d, {10'd200, 4'd3});
		repeat (30000) @(posedge clk_i);
		rd(OFS_STATUS);
		chk(rd_d[0], 1'b0);
		wait_stat(32'h1, 32'h1, 6000);
		wr(OFS_RUN_CFG, 32'h0780_0AD0);
		rd(OFS_STATUS);
		chk({rd_d[7:5], rd_d[1:0]}, 5'b00101);
		wr(OFS_RUN_CFG, 32'h0780_02D0);
		wait_stat(32'hE0, 32'hA0, 2000);
		for (int i = 0; i < 3; i++) nap(i == 2, i != 0);
		wr(OFS_RUN_EXT, 32'h8780_2820);
		wait_stat(32'hE0, 32'h40, 2000);
		// int/4 repeats every 16 cycles, so a 128-cycle window is exact
		repeat (32) @(posedge clk_i);
		n_tk = 0;
		n_hi = 0;
		repeat (128) begin
			@(posedge clk_i);
			#1;
			n_tk += int'(stick);
			n_hi += int'(sclk);
		end
		chk(n_tk, 32'd8);
		chk(n_hi, 32'd64);
		report_and_stop;
	end
endmodule
